// File: verilog/csi_tx_cfg.svh
// register offsets, field positions, reset values and counts for the
// two-port transmit control bank; included by the design modules only.
// Overview of operation
// R1 - each transmit port owns its own control register copies, routed by page select
// R2 - reads follow select bit 4; writes go to ports flagged by bits 0 and 1
// R3 - initial calibration, when enabled, goes out before any high-speed data
// R4 - software should enable initial calibration at 1.6 Gbps lane rate
// R5 - lane count field 00=4, 01=3, 10=2, 11=1 data lanes
// R6 - low-power field 00 normal, 01 data lanes LP00, 11 all lanes, 10 reserved
// R7 - continuous clock starts with the first packet sent, not before
// R8 - software should stop forwarding before toggling the output enable
// R9 - pass asserts on any enabled valid port, or all when mode bit set
// R10 - calibration payload alternates starting with 0; invert bit flips it
// R11 - single-calibration bit sends one sequence at the next idle period
// R12 - single-calibration bit clears itself after the sequence completes
// R13 - periodic mode sends a calibration sequence after each frame end
// R14 - status register reports pass and synchronization bits
// R15 - periodic sequence has the same length and pattern as the single one
`ifndef CSI_TX_CFG_SVH
`define CSI_TX_CFG_SVH

`define ADDR_PAGE_SEL 8'h32
`define ADDR_CTL 8'h33
`define ADDR_CTL2 8'h34
`define ADDR_STS 8'h35

`define SEL_WR_P0 0
`define SEL_WR_P1 1
`define SEL_RD_PORT 4
`define SEL_MASK 8'h13
`define SEL_RESET 8'h00

`define CTL_ENABLE 0
`define CTL_CONT_CLK 1
`define CTL_LP_LSB 2
`define CTL_LANES_LSB 4
`define CTL_CAL_EN 6
`define CTL_MASK 8'h7F
`define CTL_RESET 8'h00

`define CTL2_PERIODIC 0
`define CTL2_SINGLE 1
`define CTL2_INV 2
`define CTL2_PASS_MODE 3
`define CTL2_MASK 8'h0F
`define CTL2_RESET 8'h00

`define STS_PASS 0
`define STS_SYNC 1
`define STS_PORT_NUM 4

`define LP_NORMAL 2'b00
`define LP_DATA 2'b01
`define LP_ALL 2'b11

`define CAL_BITS 1024
`define CAL_BYTES (`CAL_BITS / 8)
`define CAL_PATTERN 8'hAA

`endif

// File: verilog/csi_tx_pkg.sv
// types shared by the transmit control bank and its per-port sequencer
// no dependencies; compiled ahead of the interface and the modules
package csi_tx_pkg;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_INIT_CAL,
    ST_RUN,
    ST_CAL
  } seq_state_e;

  typedef logic [7:0] reg_byte_t;
endpackage

// File: verilog/tx_port_if.sv
// register path between the bank decoder and one transmit port copy
// assumes a single clock shared by both ends
`timescale 1ns/10ps
interface tx_port_if;
  import csi_tx_pkg::*;
  logic wr_ctl;
  logic wr_ctl2;
  reg_byte_t wdata;
  reg_byte_t ctl;
  reg_byte_t ctl2;
  logic [1:0] status;

  modport bank (output wr_ctl, output wr_ctl2, output wdata,
                input ctl, input ctl2, input status);
  modport port (input wr_ctl, input wr_ctl2, input wdata,
                output ctl, output ctl2, output status);
endinterface

// File: verilog/tx_port_seq.sv
// one transmit port: its control registers and calibration sequencer
// assumes byte_en is a one-cycle pulse per link byte clock rising edge
`timescale 1ns/10ps
`include "csi_tx_cfg.svh"
module tx_port_seq import csi_tx_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  tx_port_if.port regs,
  input wire logic byte_en,
  input wire logic frame_end,
  input wire logic hs_start,
  input wire logic link_idle,
  input wire logic [3:0] rx_enabled,
  input wire logic [3:0] rx_valid,
  input wire logic sync_ok,
  output logic [3:0] lane_en,
  output logic lp_data,
  output logic lp_clk,
  output logic cont_clk,
  output logic cal_active,
  output logic [7:0] cal_byte,
  output logic hs_ready,
  output logic pass
);
  reg_byte_t ctl_q;
  reg_byte_t ctl2_q;
  seq_state_e state_q;
  logic [7:0] cnt_q;
  logic per_pend_q;
  logic cal_single_q;
  logic last_byte;
  logic start_cal;
  logic any_ok;
  logic all_ok;

  localparam logic [7:0] last_index = 8'(`CAL_BYTES - 1);

  assign last_byte = byte_en && (cnt_q == last_index);
  assign start_cal = (state_q == ST_RUN) && link_idle
                     && (ctl2_q[`CTL2_SINGLE] || per_pend_q); // R11
  assign regs.ctl = ctl_q;
  assign regs.ctl2 = ctl2_q;
  assign regs.status = {sync_ok && ctl_q[`CTL_ENABLE], pass}; // R14

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_q <= `CTL_RESET;
    end else if (regs.wr_ctl) begin
      ctl_q <= regs.wdata & `CTL_MASK;
    end
  end

  // a software write in the finishing cycle wins over the self-clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl2_q <= `CTL2_RESET;
    end else if (regs.wr_ctl2) begin
      ctl2_q <= regs.wdata & `CTL2_MASK;
    end else if (state_q == ST_CAL && last_byte && cal_single_q) begin
      ctl2_q[`CTL2_SINGLE] <= 1'b0; // R12
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
      cnt_q <= 8'h00;
      cal_single_q <= 1'b0;
    end else if (!ctl_q[`CTL_ENABLE]) begin
      state_q <= ST_OFF;
      cnt_q <= 8'h00;
      cal_single_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          cnt_q <= 8'h00;
          state_q <= ctl_q[`CTL_CAL_EN] ? ST_INIT_CAL : ST_RUN; // R3
        end
        ST_INIT_CAL: begin
          if (byte_en) cnt_q <= cnt_q + 8'h01;
          if (last_byte) state_q <= ST_RUN; // R3
        end
        ST_RUN: begin
          cnt_q <= 8'h00;
          if (start_cal) begin
            state_q <= ST_CAL;
            cal_single_q <= ctl2_q[`CTL2_SINGLE];
          end
        end
        ST_CAL: begin
          if (byte_en) cnt_q <= cnt_q + 8'h01;
          if (last_byte) state_q <= ST_RUN; // R15
        end
      endcase
    end
  end

  // a frame end in the cycle the sequence starts is kept for the next one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      per_pend_q <= 1'b0;
    end else if (!ctl_q[`CTL_ENABLE] || !ctl2_q[`CTL2_PERIODIC]) begin
      per_pend_q <= 1'b0;
    end else if (frame_end) begin
      per_pend_q <= 1'b1; // R13
    end else if (start_cal) begin
      per_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_active <= 1'b0;
      cal_byte <= 8'h00;
      hs_ready <= 1'b0;
    end else begin
      cal_active <= (state_q == ST_INIT_CAL) || (state_q == ST_CAL);
      cal_byte <= ((state_q == ST_INIT_CAL) || (state_q == ST_CAL)) ?
                  (ctl2_q[`CTL2_INV] ? ~`CAL_PATTERN : `CAL_PATTERN) : 8'h00; // R10
      hs_ready <= (state_q == ST_RUN) && !start_cal; // R3
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lane_en <= 4'h0;
      lp_data <= 1'b0;
      lp_clk <= 1'b0;
    end else begin
      unique case (ctl_q[`CTL_LANES_LSB +: 2])
        2'b00: lane_en <= 4'hF; // R5
        2'b01: lane_en <= 4'h7; // R5
        2'b10: lane_en <= 4'h3; // R5
        2'b11: lane_en <= 4'h1; // R5
      endcase
      // reserved code 10 behaves as normal operation
      lp_data <= (ctl_q[`CTL_LP_LSB +: 2] == `LP_DATA)
                 || (ctl_q[`CTL_LP_LSB +: 2] == `LP_ALL); // R6
      lp_clk <= (ctl_q[`CTL_LP_LSB +: 2] == `LP_ALL); // R6
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cont_clk <= 1'b0;
    end else if (!ctl_q[`CTL_ENABLE] || !ctl_q[`CTL_CONT_CLK]) begin
      cont_clk <= 1'b0;
    end else if (hs_start && state_q == ST_RUN) begin
      cont_clk <= 1'b1; // R7
    end
  end

  assign any_ok = |(rx_enabled & rx_valid);
  assign all_ok = (|rx_enabled) && ((rx_enabled & rx_valid) == rx_enabled);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pass <= 1'b0;
    end else begin
      pass <= ctl_q[`CTL_ENABLE] && (ctl2_q[`CTL2_PASS_MODE] ? all_ok : any_ok); // R9
    end
  end
endmodule

// File: verilog/csi2_tx_port_control.sv
// transmit-port control bank: page select, per-port register copies,
// status readback and link byte clock edge detection.
// assumes the register port is driven by the device's serial target logic
// on MCLK; TX_BYTE_CLK comes from the link PHY and is asynchronous.
`timescale 1ns/10ps
`include "csi_tx_cfg.svh"
module csi2_tx_port_control import csi_tx_pkg::*; #(
  parameter int NUM_PORTS = 2,
  parameter int NUM_RX = 4
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic TX_BYTE_CLK,
  input wire logic [NUM_PORTS-1:0] FRAME_END,
  input wire logic [NUM_PORTS-1:0] HS_START,
  input wire logic [NUM_PORTS-1:0] LINK_IDLE,
  input wire logic [NUM_RX-1:0] RX_ENABLED,
  input wire logic [NUM_RX-1:0] RX_VALID,
  input wire logic [NUM_PORTS-1:0] SYNC_OK,
  output logic [4*NUM_PORTS-1:0] LANE_EN,
  output logic [NUM_PORTS-1:0] LP_DATA,
  output logic [NUM_PORTS-1:0] LP_CLK,
  output logic [NUM_PORTS-1:0] CONT_CLK,
  output logic [NUM_PORTS-1:0] CAL_ACTIVE,
  output logic [8*NUM_PORTS-1:0] CAL_BYTE,
  output logic [NUM_PORTS-1:0] HS_READY,
  output logic [NUM_PORTS-1:0] PASS
);
  reg_byte_t sel_q;
  logic bclk_s1_q;
  logic bclk_s2_q;
  logic bclk_s3_q;
  logic byte_en;
  logic rd_port;
  reg_byte_t ctl_rd [NUM_PORTS];
  reg_byte_t ctl2_rd [NUM_PORTS];
  logic [1:0] sts_rd [NUM_PORTS];
  logic [NUM_PORTS-1:0] wr_mask;

  // byte clock is slow next to MCLK, so rising edges are found by sampling
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
    end else begin
      bclk_s1_q <= TX_BYTE_CLK;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
    end
  end

  assign byte_en = bclk_s2_q && !bclk_s3_q;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sel_q <= `SEL_RESET;
    end else if (REG_WR && REG_ADDR == `ADDR_PAGE_SEL) begin
      sel_q <= REG_WDATA & `SEL_MASK;
    end
  end

  // write fan-out may hit both copies at once; read picks exactly one
  assign wr_mask = NUM_PORTS'({sel_q[`SEL_WR_P1], sel_q[`SEL_WR_P0]}); // R2
  assign rd_port = sel_q[`SEL_RD_PORT]; // R2

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    tx_port_if pif ();

    assign pif.wdata = REG_WDATA;
    assign pif.wr_ctl = REG_WR && wr_mask[p] && (REG_ADDR == `ADDR_CTL); // R1
    assign pif.wr_ctl2 = REG_WR && wr_mask[p] && (REG_ADDR == `ADDR_CTL2); // R1
    assign ctl_rd[p] = pif.ctl;
    assign ctl2_rd[p] = pif.ctl2;
    assign sts_rd[p] = pif.status;

    tx_port_seq u_seq (
      .clk(MCLK),
      .rst_n(RST_N),
      .regs(pif.port),
      .byte_en(byte_en),
      .frame_end(FRAME_END[p]),
      .hs_start(HS_START[p]),
      .link_idle(LINK_IDLE[p]),
      .rx_enabled(RX_ENABLED),
      .rx_valid(RX_VALID),
      .sync_ok(SYNC_OK[p]),
      .lane_en(LANE_EN[4*p +: 4]),
      .lp_data(LP_DATA[p]),
      .lp_clk(LP_CLK[p]),
      .cont_clk(CONT_CLK[p]),
      .cal_active(CAL_ACTIVE[p]),
      .cal_byte(CAL_BYTE[8*p +: 8]),
      .hs_ready(HS_READY[p]),
      .pass(PASS[p])
    );
  end

  // read data is held until the next read; unmapped offsets read zero
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        `ADDR_PAGE_SEL: REG_RDATA <= sel_q;
        `ADDR_CTL: REG_RDATA <= ctl_rd[rd_port]; // R1
        `ADDR_CTL2: REG_RDATA <= ctl2_rd[rd_port]; // R1
        `ADDR_STS: REG_RDATA <= {3'b000, rd_port, 2'b00, sts_rd[rd_port]}; // R14
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end
endmodule

// File: tb/csi2_tx_port_control_chk.sv
// port-level checks on transmit port 0 of the control bank
// bound to every bank instance; sees top-level ports only
`timescale 1ns/10ps
module csi2_tx_port_control_chk #(
  parameter int NUM_PORTS = 2,
  parameter int NUM_RX = 4
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic TX_BYTE_CLK,
  input wire logic [NUM_PORTS-1:0] HS_START,
  input wire logic [NUM_RX-1:0] RX_ENABLED,
  input wire logic [NUM_RX-1:0] RX_VALID,
  input wire logic [4*NUM_PORTS-1:0] LANE_EN,
  input wire logic [NUM_PORTS-1:0] LP_DATA,
  input wire logic [NUM_PORTS-1:0] LP_CLK,
  input wire logic [NUM_PORTS-1:0] CONT_CLK,
  input wire logic [NUM_PORTS-1:0] CAL_ACTIVE,
  input wire logic [8*NUM_PORTS-1:0] CAL_BYTE,
  input wire logic [NUM_PORTS-1:0] HS_READY,
  input wire logic [NUM_PORTS-1:0] PASS
);
  logic [2:0] sync_q;
  logic [7:0] cnt_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // own edge finder, so the byte count does not lean on the design
  always_ff @(posedge MCLK) begin
    sync_q <= {sync_q[1:0], TX_BYTE_CLK};
  end
  always_ff @(posedge MCLK) begin
    if (!RST_N || !CAL_ACTIVE[0]) begin
      cnt_q <= 8'h00;
    end else if (sync_q[1] && !sync_q[2]) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  cal_no_hs_a: assert property (CAL_ACTIVE[0] |-> !HS_READY[0])
    else $error("hs ready during calibration");
  cal_pattern_a: assert property (CAL_ACTIVE[0] |-> CAL_BYTE[7:0] inside {8'hAA, 8'h55})
    else $error("bad calibration byte");
  idle_byte_a: assert property (!CAL_ACTIVE[0] |-> CAL_BYTE[7:0] == 8'h00)
    else $error("pattern outside calibration");
  cal_length_a: assert property ($fell(CAL_ACTIVE[0]) |-> cnt_q inside {[8'h7E:8'h81]})
    else $error("calibration length off");
  lane_code_a: assert property ($onehot({1'b0, LANE_EN[3:0]} + 5'h01))
    else $error("lane enables not contiguous");
  lp_pair_a: assert property (LP_CLK[0] |-> LP_DATA[0])
    else $error("clock lane forced alone");
  cont_start_a: assert property ($rose(CONT_CLK[0]) |-> $past(HS_START[0]))
    else $error("continuous clock before packet");
  pass_cause_a: assert property (PASS[0] |-> $past(|(RX_ENABLED & RX_VALID)))
    else $error("pass without valid port");
  status_rsv_a: assert property (REG_RD && REG_ADDR == 8'h35 |=> (REG_RDATA & 8'hEC) == 8'h00)
    else $error("status reserved bits set");
  cover property ($fell(CAL_ACTIVE[0]));
  cover property ($rose(CONT_CLK[0]));
  cover property (PASS[0] && RX_ENABLED == 4'h3);
endmodule

bind csi2_tx_port_control csi2_tx_port_control_chk #(.NUM_PORTS(NUM_PORTS), .NUM_RX(NUM_RX)) i_chk (
  .MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .TX_BYTE_CLK(TX_BYTE_CLK), .HS_START(HS_START), .RX_ENABLED(RX_ENABLED),
  .RX_VALID(RX_VALID), .LANE_EN(LANE_EN), .LP_DATA(LP_DATA), .LP_CLK(LP_CLK),
  .CONT_CLK(CONT_CLK), .CAL_ACTIVE(CAL_ACTIVE), .CAL_BYTE(CAL_BYTE),
  .HS_READY(HS_READY), .PASS(PASS));

// File: tb/csi_rx_model.sv
// receiving end of transmit port 0: link byte clock and calibration tally
// byte clock runs free, as the link keeps it up between frames
`timescale 1ns/10ps
module csi_rx_model (
  input wire logic clr,
  input wire logic cal_active,
  input wire logic [7:0] cal_byte,
  output logic byte_clk,
  output int n_bytes,
  output logic [7:0] first_byte
);
  initial byte_clk = 1'b0;
  always #400 byte_clk = ~byte_clk;
  always @(posedge byte_clk or posedge clr) begin
    if (clr) begin
      n_bytes <= 0;
    end else if (cal_active) begin
      if (n_bytes == 0) begin
        first_byte <= cal_byte;
      end
      n_bytes <= n_bytes + 1;
    end
  end
endmodule

// File: tb/tb_csi2_tx_port_control.sv
// self-checking bench for the transmit control bank, port 0 traffic
// needs csi_rx_model for the byte clock; checker arrives by bind
`timescale 1ns/10ps
module tb_csi2_tx_port_control;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [1:0] FRAME_END = 2'h0;
  logic [1:0] HS_START = 2'h0;
  logic [1:0] LINK_IDLE = 2'h0;
  logic [3:0] RX_ENABLED = 4'h0;
  logic [3:0] RX_VALID = 4'h0;
  logic [1:0] SYNC_OK = 2'h0;
  logic clr = 1'b1;
  logic TX_BYTE_CLK;
  logic [7:0] REG_RDATA, LANE_EN, first_byte;
  logic [15:0] CAL_BYTE;
  logic [1:0] LP_DATA, LP_CLK, CONT_CLK, CAL_ACTIVE, HS_READY, PASS;
  int n_bytes;
  int n_mismatch = 0;
  int comparisons = 0;
  always #50 MCLK = ~MCLK;
  csi2_tx_port_control i_csi2_tx_port_control (.MCLK(MCLK), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .TX_BYTE_CLK(TX_BYTE_CLK), .FRAME_END(FRAME_END),
    .HS_START(HS_START), .LINK_IDLE(LINK_IDLE), .RX_ENABLED(RX_ENABLED),
    .RX_VALID(RX_VALID), .SYNC_OK(SYNC_OK), .LANE_EN(LANE_EN), .LP_DATA(LP_DATA),
    .LP_CLK(LP_CLK), .CONT_CLK(CONT_CLK), .CAL_ACTIVE(CAL_ACTIVE),
    .CAL_BYTE(CAL_BYTE), .HS_READY(HS_READY), .PASS(PASS));
  csi_rx_model i_csi_rx_model (.clr(clr), .cal_active(CAL_ACTIVE[0]),
    .cal_byte(CAL_BYTE[7:0]), .byte_clk(TX_BYTE_CLK), .n_bytes(n_bytes),
    .first_byte(first_byte));
  task automatic chk(input bit ok, input string what);
    comparisons++;
    if (!ok) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    @(negedge MCLK);
    chk(REG_RDATA === e, "read data");
  endtask
  // clears the receiver tally; leaves the caller on a rising edge
  task automatic arm;
    @(posedge MCLK);
    clr <= 1'b1;
    @(posedge MCLK);
    clr <= 1'b0;
  endtask
  task automatic wait_cal(input logic v);
    for (int i = 0; i < 3000 && CAL_ACTIVE[0] !== v; i++) @(negedge MCLK);
    chk(CAL_ACTIVE[0] === v, "calibration state");
  endtask
  task automatic t_paging;
    rd(8'h33, 8'h00);
    wr(8'h33, 8'h30);
    rd(8'h33, 8'h00);
    wr(8'h32, 8'hFF);
    rd(8'h32, 8'h13);
    wr(8'h32, 8'h01);
    wr(8'h33, 8'hB0);
    rd(8'h33, 8'h30);
    chk(LANE_EN === 8'hF1, "write reached one port");
    wr(8'h32, 8'h12);
    rd(8'h33, 8'h00);
    wr(8'h33, 8'h20);
    rd(8'h33, 8'h20);
    chk(LANE_EN === 8'h31, "write reached port 1 only");
    rd(8'h35, 8'h10);
    rd(8'h40, 8'h00);
    wr(8'h32, 8'h13);
    wr(8'h33, 8'h10);
    rd(8'h33, 8'h10);
    chk(LANE_EN === 8'h77, "write reached both ports");
    wr(8'h32, 8'h01);
  endtask
  task automatic t_codes;
    logic [3:0] lanes [4] = '{4'hF, 4'h7, 4'h3, 4'h1};
    for (int i = 0; i < 4; i++) begin
      wr(8'h33, {2'b00, 2'(i), 2'(i), 2'b00});
      repeat (2) @(negedge MCLK);
      chk(LANE_EN[3:0] === lanes[i], "lane count");
      chk(LP_DATA[0] === 1'(i), "data lanes low power");
      chk(LP_CLK[0] === (i == 3), "clock lane low power");
    end
  endtask
  task automatic t_init_cal;
    wr(8'h34, 8'h04);
    arm;
    wr(8'h33, 8'h41);
    wait_cal(1'b1);
    chk(CAL_BYTE[7:0] === 8'h55 && HS_READY[0] === 1'b0, "initial calibration");
    wait_cal(1'b0);
    repeat (2) @(negedge MCLK);
    chk(HS_READY[0] === 1'b1, "hs after calibration");
    chk(n_bytes inside {[127:129]} && first_byte === 8'h55, "initial length");
  endtask
  task automatic t_single;
    wr(8'h34, 8'h02);
    repeat (20) @(negedge MCLK);
    chk(CAL_ACTIVE[0] === 1'b0, "waits for idle");
    arm;
    LINK_IDLE <= 2'h1;
    wait_cal(1'b1);
    chk(CAL_BYTE[7:0] === 8'hAA, "plain pattern");
    wait_cal(1'b0);
    chk(n_bytes inside {[127:129]}, "single length");
    rd(8'h34, 8'h00);
  endtask
  task automatic t_periodic;
    wr(8'h34, 8'h01);
    repeat (20) @(negedge MCLK);
    chk(CAL_ACTIVE[0] === 1'b0, "no frame end yet");
    arm;
    FRAME_END <= 2'h1;
    @(posedge MCLK);
    FRAME_END <= 2'h0;
    wait_cal(1'b1);
    wait_cal(1'b0);
    chk(n_bytes inside {[127:129]}, "periodic length");
    repeat (20) @(negedge MCLK);
    chk(CAL_ACTIVE[0] === 1'b0, "one per frame end");
  endtask
  task automatic t_cont_clk;
    wr(8'h33, 8'h03);
    repeat (5) @(negedge MCLK);
    chk(CONT_CLK[0] === 1'b0, "clock waits for packet");
    @(posedge MCLK);
    HS_START <= 2'h1;
    @(posedge MCLK);
    HS_START <= 2'h0;
    repeat (2) @(negedge MCLK);
    chk(CONT_CLK[0] === 1'b1, "continuous after packet");
  endtask
  task automatic t_pass;
    @(posedge MCLK);
    RX_ENABLED <= 4'h3;
    RX_VALID <= 4'h1;
    SYNC_OK <= 2'h1;
    wr(8'h34, 8'h00);
    repeat (2) @(negedge MCLK);
    chk(PASS === 2'h1, "pass on any port");
    rd(8'h35, 8'h03);
    wr(8'h34, 8'h08);
    repeat (2) @(negedge MCLK);
    chk(PASS[0] === 1'b0, "pass needs all");
    @(posedge MCLK);
    RX_VALID <= 4'h3;
    repeat (2) @(negedge MCLK);
    chk(PASS[0] === 1'b1, "pass all valid");
  endtask
  // reset in mid-run must drop LANE_EN, CAL_ACTIVE, PASS, CONT_CLK, HS_READY and read data, and clear page select and port 0 CTL
  task automatic t_reset;
    @(posedge MCLK);
    RST_N <= 1'b0;
    repeat (2) @(negedge MCLK);
    chk({LANE_EN, CAL_ACTIVE, PASS, CONT_CLK, HS_READY, REG_RDATA} === '0, "outputs in reset");
    @(posedge MCLK);
    RST_N <= 1'b1;
    rd(8'h32, 8'h00);
    rd(8'h33, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    t_paging;
    t_codes;
    t_init_cal;
    t_single;
    t_periodic;
    t_cont_clk;
    t_pass;
    t_reset;
    report_and_stop;
  end
endmodule
